// [protector_comparator_config.sv]
// protector comparator configuration bank with deglitch and events
`timescale 1ns/1ps
`default_nettype none
module protector_comparator_config
  import pcc_pkg::*;
#(
  parameter int unsigned SLOW_DG_CYC = DG_500_CYC,
  parameter int unsigned NUM_CH      = NUM_TEMP_CH
)(
  input  wire logic              clk_i,
  input  wire logic              rst_n_i,
  input  wire logic [ADDR_W-1:0] addr_i,
  input  wire logic [DATA_W-1:0] wdata_i,
  input  wire logic              wr_i,
  input  wire logic              rd_i,
  output logic      [DATA_W-1:0] rdata_o,
  input  wire logic [NUM_CH-1:0] hot_cmp_i,
  input  wire logic [NUM_CH-1:0] cold_cmp_i,
  input  wire logic              ov_cmp_i,
  input  wire logic              uv_cmp_i,
  input  wire logic              bal_cmp_i,
  input  wire logic [6:0]        ov_code_i,
  input  wire logic [6:0]        uv_code_i,
  output logic      [NUM_CH-1:0] temp_prot_en_o,
  output logic      [DG_W-1:0]   thermal_filter_time_o,
  output logic      [DG_W-1:0]   voltage_filter_time_o,
  output logic      [NUM_CH-1:0] hot_flag_o,
  output logic      [NUM_CH-1:0] cold_flag_o,
  output logic                   ov_flag_o,
  output logic                   uv_flag_o,
  output logic                   balance_finished_o,
  output logic      [6:0]        hot_trip_level_o,
  output logic      [6:0]        cold_trip_level_o,
  output logic      [12:0]       ov_trip_mv_o,
  output logic      [11:0]       uv_trip_mv_o,
  output logic                   irq_o
);

  localparam int unsigned NT   = 2 * NUM_CH;
  localparam int unsigned NCMP = NT + 3;

  // --------------------------------------------------------------
  // state
  // --------------------------------------------------------------
  logic [7:0]        en_q;
  logic [7:0]        thr_q;
  logic [7:0]        dg_q;
  logic [7:0]        mask_q;
  logic [EVT_W-1:0]  status_q;
  logic [EVT_W-1:0]  evt_set;
  logic [7:0]        rdata_q;
  logic [7:0]        rd_val;
  logic [NCMP-1:0]   sync1_q;
  logic [NCMP-1:0]   sync2_q;
  logic [NCMP-1:0]   flags;
  logic [NCMP-1:0]   flag_prev_q;
  logic [NCMP-1:0]   rise;
  logic [6:0]        hot_pct;
  logic [6:0]        cold_pct;
  logic [12:0]       ov_mv;
  logic [11:0]       uv_mv;
  logic [6:0]        hot_lvl_q;
  logic [6:0]        cold_lvl_q;
  logic [12:0]       ov_mv_q;
  logic [11:0]       uv_mv_q;

  dg_if #(.N(NT), .CW(CNT_W)) t_if ();
  dg_if #(.N(3),  .CW(CNT_W)) v_if ();

  function automatic logic [CNT_W-1:0] dg_lim(input logic [1:0] sel);
    logic [CNT_W-1:0] r;
    r = '0;
    unique case (sel)
      2'h0: r = CNT_W'(DG_25_CYC);
      2'h1: r = CNT_W'(DG_50_CYC);
      2'h2: r = CNT_W'(DG_100_CYC);
      2'h3: r = CNT_W'(SLOW_DG_CYC);
    endcase
    return r;
  endfunction : dg_lim

  // --------------------------------------------------------------
  // register writes
  // --------------------------------------------------------------
  // spare bits are kept and read back, they steer nothing
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      en_q <= RST_TEMP_PROT_EN;
    else if (wr_i && addr_i == ADDR_TEMP_PROT_EN)
      en_q <= wdata_i;
  end

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      thr_q <= RST_TEMP_THRESH;
    else if (wr_i && addr_i == ADDR_TEMP_THRESH)
      thr_q <= wdata_i;
  end

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      dg_q <= RST_FILTER_TIME;
    else if (wr_i && addr_i == ADDR_FILTER_TIME)
      dg_q <= wdata_i;
  end

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      mask_q <= RST_EVT_MASK;
    else if (wr_i && addr_i == ADDR_EVT_MASK)
      mask_q <= wdata_i;
  end

  assign temp_prot_en_o        = en_q[NUM_CH-1:0];
  assign thermal_filter_time_o = dg_q[THERM_FT_LSB +: DG_W];
  assign voltage_filter_time_o = dg_q[VOLT_DG_LSB +: DG_W];

  // --------------------------------------------------------------
  // comparator inputs: asynchronous, two-flop synchroniser
  // --------------------------------------------------------------
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      sync1_q <= '0;
      sync2_q <= '0;
    end
    else
    begin
      sync1_q <= {bal_cmp_i, uv_cmp_i, ov_cmp_i, cold_cmp_i, hot_cmp_i};
      sync2_q <= sync1_q;
    end
  end

  // --------------------------------------------------------------
  // deglitch filters
  // --------------------------------------------------------------
  // gating before the filter makes a disabled channel restart
  assign t_if.raw = {sync2_q[NT-1:NUM_CH] & en_q[NUM_CH-1:0],
                     sync2_q[NUM_CH-1:0] & en_q[NUM_CH-1:0]};
  assign t_if.lim = dg_lim(dg_q[THERM_FT_LSB +: DG_W]);
  assign v_if.raw = sync2_q[NCMP-1:NT];
  assign v_if.lim = dg_lim(dg_q[VOLT_DG_LSB +: DG_W]);

  deglitch_bank #(.N(NT), .CW(CNT_W)) u_thermal_filter_time (
    .clk_i   (clk_i),
    .rst_n_i (rst_n_i),
    .d       (t_if)
  );

  deglitch_bank #(.N(3), .CW(CNT_W)) u_volt_dg (
    .clk_i   (clk_i),
    .rst_n_i (rst_n_i),
    .d       (v_if)
  );

  assign hot_flag_o         = t_if.flag[NUM_CH-1:0];
  assign cold_flag_o        = t_if.flag[NT-1:NUM_CH];
  assign ov_flag_o          = v_if.flag[0];
  assign uv_flag_o          = v_if.flag[1];
  assign balance_finished_o = v_if.flag[2];

  // --------------------------------------------------------------
  // trip levels
  // --------------------------------------------------------------
  trip_level_decode u_decode (
    .hot_code_i  (thr_q[HOT_LSB +: THR_W]),
    .cold_code_i (thr_q[COLD_LSB +: THR_W]),
    .ov_code_i   (ov_code_i),
    .uv_code_i   (uv_code_i),
    .hot_pct_o   (hot_pct),
    .cold_pct_o  (cold_pct),
    .ov_mv_o     (ov_mv),
    .uv_mv_o     (uv_mv)
  );

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      hot_lvl_q  <= HOT_PCT_BASE;
      cold_lvl_q <= COLD_PCT_BASE;
      ov_mv_q    <= OV_BASE_MV;
      uv_mv_q    <= UV_BASE_MV;
    end
    else
    begin
      hot_lvl_q  <= hot_pct;
      cold_lvl_q <= cold_pct;
      ov_mv_q    <= ov_mv;
      uv_mv_q    <= uv_mv;
    end
  end

  assign hot_trip_level_o  = hot_lvl_q;
  assign cold_trip_level_o = cold_lvl_q;
  assign ov_trip_mv_o      = ov_mv_q;
  assign uv_trip_mv_o      = uv_mv_q;

  // --------------------------------------------------------------
  // events and interrupt
  // --------------------------------------------------------------
  assign flags = {v_if.flag, t_if.flag};
  assign rise  = flags & ~flag_prev_q;

  always_comb
  begin
    evt_set           = '0;
    evt_set[EVT_HOT]  = |rise[NUM_CH-1:0];
    evt_set[EVT_COLD] = |rise[NT-1:NUM_CH];
    evt_set[EVT_OV]   = rise[NT];
    evt_set[EVT_UV]   = rise[NT+1];
    evt_set[EVT_BAL]  = rise[NT+2];
  end

  // a new event in the clearing read's cycle survives
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      flag_prev_q <= '0;
      status_q    <= '0;
    end
    else
    begin
      flag_prev_q <= flags;
      if (rd_i && addr_i == ADDR_EVT_STATUS)
        status_q <= evt_set;
      else
        status_q <= status_q | evt_set;
    end
  end

  assign irq_o = |(status_q & mask_q[EVT_W-1:0]);

  // --------------------------------------------------------------
  // read path
  // --------------------------------------------------------------
  always_comb
  begin
    unique case (addr_i)
      ADDR_TEMP_PROT_EN: rd_val = en_q;
      ADDR_TEMP_THRESH:  rd_val = thr_q;
      ADDR_FILTER_TIME:  rd_val = dg_q;
      ADDR_EVT_STATUS:   rd_val = 8'(status_q);
      ADDR_EVT_MASK:     rd_val = mask_q;
      default:           rd_val = RDATA_IDLE;
    endcase
  end

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      rdata_q <= RDATA_IDLE;
    else if (rd_i)
      rdata_q <= rd_val;
    else
      rdata_q <= RDATA_IDLE;
  end

  assign rdata_o = rdata_q;

  // --------------------------------------------------------------
  // checks
  // --------------------------------------------------------------
  logic             past_ok_q;
  logic [CNT_W-1:0] run_t_q;
  logic [CNT_W-1:0] run_v_q;

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      past_ok_q <= 1'b0;
      run_t_q   <= '0;
      run_v_q   <= '0;
    end
    else
    begin
      past_ok_q <= 1'b1;
      if (!t_if.raw[0])
        run_t_q <= '0;
      else if (run_t_q != '1)
        run_t_q <= run_t_q + 1'b1;
      if (!v_if.raw[0])
        run_v_q <= '0;
      else if (run_v_q != '1)
        run_v_q <= run_v_q + 1'b1;
    end
  end

  property p_en_write;
    @(posedge clk_i) disable iff (!rst_n_i)
    wr_i && addr_i == ADDR_TEMP_PROT_EN
      |=> temp_prot_en_o == $past(wdata_i[NUM_CH-1:0]);
  endproperty
  a_en_write: assert property (p_en_write)
    else $error("enable write not stored");

  property p_disabled_quiet;
    @(posedge clk_i) disable iff (!rst_n_i)
    past_ok_q |->
      ((hot_flag_o | cold_flag_o) & ~$past(en_q[NUM_CH-1:0])) == '0;
  endproperty
  a_disabled_quiet: assert property (p_disabled_quiet)
    else $error("disabled channel raised a flag");

  property p_hot_level;
    @(posedge clk_i) disable iff (!rst_n_i)
    past_ok_q |->
      hot_trip_level_o == HOT_PCT_BASE + 7'($past(thr_q[7:4]));
  endproperty
  a_hot_level: assert property (p_hot_level)
    else $error("hot trip level wrong");

  property p_cold_level;
    @(posedge clk_i) disable iff (!rst_n_i)
    past_ok_q |->
      cold_trip_level_o == COLD_PCT_BASE + 7'($past(thr_q[3:0]));
  endproperty
  a_cold_level: assert property (p_cold_level)
    else $error("cold trip level wrong");

  property p_temp_interval;
    @(posedge clk_i) disable iff (!rst_n_i)
    $rose(hot_flag_o[0]) && $stable(dg_q)
      |-> run_t_q == dg_lim(dg_q[3:2]);
  endproperty
  a_temp_interval: assert property (p_temp_interval)
    else $error("thermal flag not at selected interval");

  property p_volt_interval;
    @(posedge clk_i) disable iff (!rst_n_i)
    $rose(ov_flag_o) && $stable(dg_q)
      |-> run_v_q == dg_lim(dg_q[1:0]);
  endproperty
  a_volt_interval: assert property (p_volt_interval)
    else $error("voltage flag not at selected interval");

  property p_ov_saturate;
    @(posedge clk_i) disable iff (!rst_n_i)
    past_ok_q && $past(ov_code_i) >= OV_SAT_CODE
      |-> ov_trip_mv_o == OV_MAX_MV;
  endproperty
  a_ov_saturate: assert property (p_ov_saturate)
    else $error("over-voltage level not saturated");

  property p_uv_level;
    @(posedge clk_i) disable iff (!rst_n_i)
    past_ok_q |->
      uv_trip_mv_o == UV_BASE_MV + 12'(13'($past(uv_code_i)) * V_STEP_MV);
  endproperty
  a_uv_level: assert property (p_uv_level)
    else $error("under-voltage level wrong");

endmodule : protector_comparator_config
`default_nettype wire

// [pcc_pkg.sv]
// constants for the protector comparator configuration bank
package pcc_pkg;

  // --------------------------------------------------------------
  // register map
  // --------------------------------------------------------------
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 8;
  localparam logic [7:0] ADDR_TEMP_PROT_EN = 8'h2C;
  localparam logic [7:0] ADDR_TEMP_THRESH  = 8'h2D;
  localparam logic [7:0] ADDR_FILTER_TIME  = 8'h2E;
  localparam logic [7:0] ADDR_EVT_STATUS   = 8'h40;
  localparam logic [7:0] ADDR_EVT_MASK     = 8'h41;
  localparam logic [7:0] RST_TEMP_PROT_EN  = 8'h00;
  localparam logic [7:0] RST_TEMP_THRESH   = 8'h00;
  localparam logic [7:0] RST_FILTER_TIME   = 8'h00;
  localparam logic [7:0] RST_EVT_MASK      = 8'h00;
  localparam logic [7:0] RDATA_IDLE        = 8'h00;

  // --------------------------------------------------------------
  // fields
  // --------------------------------------------------------------
  localparam int unsigned NUM_TEMP_CH  = 6;
  localparam int unsigned HOT_LSB      = 4;
  localparam int unsigned COLD_LSB     = 0;
  localparam int unsigned THR_W        = 4;
  localparam int unsigned THERM_FT_LSB = 2;
  localparam int unsigned VOLT_DG_LSB  = 0;
  localparam int unsigned DG_W         = 2;
  localparam int unsigned EVT_HOT      = 0;
  localparam int unsigned EVT_COLD     = 1;
  localparam int unsigned EVT_OV       = 2;
  localparam int unsigned EVT_UV       = 3;
  localparam int unsigned EVT_BAL      = 4;
  localparam int unsigned EVT_W        = 5;

  // --------------------------------------------------------------
  // trip level scaling
  // --------------------------------------------------------------
  localparam logic [6:0]  HOT_PCT_BASE  = 7'h14;
  localparam logic [6:0]  COLD_PCT_BASE = 7'h3C;
  localparam logic [12:0] OV_BASE_MV    = 13'h7D0;
  localparam logic [12:0] OV_MAX_MV     = 13'h1388;
  localparam logic [6:0]  OV_SAT_CODE   = 7'h78;
  localparam logic [11:0] UV_BASE_MV    = 12'h2BC;
  localparam logic [12:0] V_STEP_MV     = 13'h19;

  // --------------------------------------------------------------
  // filter times, least times so cycle counts round up
  // --------------------------------------------------------------
  localparam longint unsigned CLK_HZ   = 64'h1312D00;
  localparam longint unsigned US_PER_S = 64'hF4240;
  localparam longint unsigned DG_25_US  = 64'h19;
  localparam longint unsigned DG_50_US  = 64'h32;
  localparam longint unsigned DG_100_US = 64'h64;
  localparam longint unsigned DG_500_US = 64'h1F4;
  localparam int unsigned DG_25_CYC =
    int'((DG_25_US * CLK_HZ + US_PER_S - 1) / US_PER_S);
  localparam int unsigned DG_50_CYC =
    int'((DG_50_US * CLK_HZ + US_PER_S - 1) / US_PER_S);
  localparam int unsigned DG_100_CYC =
    int'((DG_100_US * CLK_HZ + US_PER_S - 1) / US_PER_S);
  localparam int unsigned DG_500_CYC =
    int'((DG_500_US * CLK_HZ + US_PER_S - 1) / US_PER_S);
  localparam int unsigned CNT_W = 14;

endpackage : pcc_pkg

// [dg_if.sv]
// link between the config bank and a bank of deglitch filters
`timescale 1ns/1ps
`default_nettype none
interface dg_if #(
  parameter int unsigned N  = 1,
  parameter int unsigned CW = 14
);
  logic [N-1:0]  raw;
  logic [CW-1:0] lim;
  logic [N-1:0]  flag;

  modport filt (input raw, input lim, output flag);
  modport ctl  (output raw, output lim, input flag);
endinterface : dg_if
`default_nettype wire

// [deglitch_bank.sv]
// bank of continuous-assertion deglitch filters
`timescale 1ns/1ps
`default_nettype none
module deglitch_bank #(
  parameter int unsigned N  = 1,
  parameter int unsigned CW = 14
)(
  input  wire logic clk_i,
  input  wire logic rst_n_i,
  dg_if.filt        d
);

  logic [CW-1:0] cnt_q [N];
  logic [N-1:0]  flag_q;

  assign d.flag = flag_q;

  for (genvar i = 0; i < N; i++)
  begin : g_ch
    // a limit lowered mid-run takes effect at once (>=)
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
      if (!rst_n_i)
      begin
        cnt_q[i]  <= '0;
        flag_q[i] <= 1'b0;
      end
      else if (!d.raw[i])
      begin
        cnt_q[i]  <= '0;
        flag_q[i] <= 1'b0;
      end
      else if (cnt_q[i] >= CW'(d.lim - 1'b1))
        flag_q[i] <= 1'b1;
      else
        cnt_q[i] <= cnt_q[i] + 1'b1;
    end

    property p_rise_after_full_time;
      @(posedge clk_i) disable iff (!rst_n_i)
      $rose(flag_q[i]) |->
        $past(d.raw[i]) && ($past(cnt_q[i]) >= CW'($past(d.lim) - 1'b1));
    endproperty
    a_rise_after_full_time: assert property (p_rise_after_full_time)
      else $error("deglitch flag rose before the full interval");

    property p_drop_restarts;
      @(posedge clk_i) disable iff (!rst_n_i)
      !d.raw[i] |=> !flag_q[i] && (cnt_q[i] == '0);
    endproperty
    a_drop_restarts: assert property (p_drop_restarts)
      else $error("deglitch did not restart on deassertion");
  end

endmodule : deglitch_bank
`default_nettype wire

// [trip_level_decode.sv]
// threshold codes to trip levels in percent and millivolts
`timescale 1ns/1ps
`default_nettype none
module trip_level_decode
  import pcc_pkg::*;
(
  input  wire logic [THR_W-1:0] hot_code_i,
  input  wire logic [THR_W-1:0] cold_code_i,
  input  wire logic [6:0]       ov_code_i,
  input  wire logic [6:0]       uv_code_i,
  output logic      [6:0]       hot_pct_o,
  output logic      [6:0]       cold_pct_o,
  output logic      [12:0]      ov_mv_o,
  output logic      [11:0]      uv_mv_o
);

  assign hot_pct_o  = HOT_PCT_BASE + 7'(hot_code_i);
  assign cold_pct_o = COLD_PCT_BASE + 7'(cold_code_i);

  // top eight codes all pin to the ceiling
  assign ov_mv_o = (ov_code_i >= OV_SAT_CODE) ? OV_MAX_MV
                 : OV_BASE_MV + 13'(13'(ov_code_i) * V_STEP_MV);
  assign uv_mv_o = UV_BASE_MV + 12'(13'(uv_code_i) * V_STEP_MV);

endmodule : trip_level_decode
`default_nettype wire

// [test_protector_comparator_config.sv]
// self-checking bench for the protector comparator configuration bank
`timescale 1ns/1ps
`default_nettype none
module test_protector_comparator_config
  import pcc_pkg::*;
;
  // ------------------------------------------------------------------
  // signals
  // ------------------------------------------------------------------
  // short slow filter time keeps the run brief
  localparam int unsigned SLOW = 40;
  logic              clk_i;
  logic              rst_n_i;
  logic [7:0]        addr_i;
  logic [7:0]        wdata_i;
  logic              wr_i;
  logic              rd_i;
  logic [7:0]        rdata_o;
  logic [5:0]        hot_cmp_i;
  logic [5:0]        cold_cmp_i;
  logic              ov_cmp_i;
  logic              uv_cmp_i;
  logic              bal_cmp_i;
  logic [6:0]        ov_code_i;
  logic [6:0]        uv_code_i;
  logic [5:0]        temp_prot_en_o;
  logic [1:0]        thermal_filter_time_o;
  logic [1:0]        voltage_filter_time_o;
  logic [5:0]        hot_flag_o;
  logic [5:0]        cold_flag_o;
  logic              ov_flag_o;
  logic              uv_flag_o;
  logic              balance_finished_o;
  logic [6:0]        hot_trip_level_o;
  logic [6:0]        cold_trip_level_o;
  logic [12:0]       ov_trip_mv_o;
  logic [11:0]       uv_trip_mv_o;
  logic              irq_o;
  int                err_count;
  int                num_checks;
  logic [31:0]       rng_q;
  logic [7:0]        shadow [3];
  int                lim [4];

  protector_comparator_config #(
    .SLOW_DG_CYC (SLOW),
    .NUM_CH      (6)
  ) protector_comparator_config_inst (
    .clk_i (clk_i), .rst_n_i (rst_n_i), .addr_i (addr_i),
    .wdata_i (wdata_i), .wr_i (wr_i), .rd_i (rd_i), .rdata_o (rdata_o),
    .hot_cmp_i (hot_cmp_i), .cold_cmp_i (cold_cmp_i),
    .ov_cmp_i (ov_cmp_i), .uv_cmp_i (uv_cmp_i), .bal_cmp_i (bal_cmp_i),
    .ov_code_i (ov_code_i), .uv_code_i (uv_code_i),
    .temp_prot_en_o (temp_prot_en_o),
    .thermal_filter_time_o (thermal_filter_time_o),
    .voltage_filter_time_o (voltage_filter_time_o),
    .hot_flag_o (hot_flag_o), .cold_flag_o (cold_flag_o),
    .ov_flag_o (ov_flag_o), .uv_flag_o (uv_flag_o),
    .balance_finished_o (balance_finished_o),
    .hot_trip_level_o (hot_trip_level_o),
    .cold_trip_level_o (cold_trip_level_o),
    .ov_trip_mv_o (ov_trip_mv_o), .uv_trip_mv_o (uv_trip_mv_o),
    .irq_o (irq_o)
  );

  always #25 clk_i = ~clk_i;

  // ------------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------------
  function automatic logic [31:0] xorshift();
    rng_q = rng_q ^ (rng_q << 13);
    rng_q = rng_q ^ (rng_q >> 17);
    rng_q = rng_q ^ (rng_q << 5);
    return rng_q;
  endfunction : xorshift

  function automatic logic [15:0] exp_ov(input logic [6:0] c);
    // top codes all clamp to the highest level
    return (c >= 7'h78) ? 16'h1388 : 16'h07D0 + 16'(c) * 16'h0019;
  endfunction : exp_ov

  function automatic logic [15:0] exp_uv(input logic [6:0] c);
    return 16'h02BC + 16'(c) * 16'h0019;
  endfunction : exp_uv

  function automatic logic get_flag(input int sel);
    case (sel)
      0: return hot_flag_o[0];
      1: return cold_flag_o[5];
      2: return ov_flag_o;
      3: return uv_flag_o;
      default: return balance_finished_o;
    endcase
  endfunction : get_flag

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      err_count++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic cycles(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask : cycles

  task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    addr_i  <= a;
    wdata_i <= d;
    wr_i    <= 1'b1;
    @(posedge clk_i);
    wr_i    <= 1'b0;
  endtask : reg_wr

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk_i);
    addr_i <= a;
    rd_i   <= 1'b1;
    @(posedge clk_i);
    rd_i   <= 1'b0;
    #1;
    chk(16'(rdata_o), 16'(exp));
  endtask : rd_chk

  task automatic set_raw(input int sel, input logic v);
    @(posedge clk_i);
    case (sel)
      0: hot_cmp_i[0] <= v;
      1: cold_cmp_i[5] <= v;
      2: ov_cmp_i <= v;
      3: uv_cmp_i <= v;
      default: bal_cmp_i <= v;
    endcase
  endtask : set_raw

  // one-cycle dropout near the end must restart the whole interval
  task automatic filt_run(input int sel, input int l);
    set_raw(sel, 1'b1);
    cycles(l - 3);
    set_raw(sel, 1'b0);
    set_raw(sel, 1'b1);
    cycles(l);
    chk(16'(get_flag(sel)), 16'h0000);
    cycles(3);
    chk(16'(get_flag(sel)), 16'h0001);
    chk(16'(irq_o), 16'h0001);
    rd_chk(ADDR_EVT_STATUS, 8'(1 << sel));
    cycles(1);
    chk(16'(irq_o), 16'h0000);
    set_raw(sel, 1'b0);
    cycles(3);
    chk(16'(get_flag(sel)), 16'h0000);
  endtask : filt_run

  task automatic finish_test();
    if (err_count == 0 && num_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : finish_test

  // ------------------------------------------------------------------
  // watchdog
  // ------------------------------------------------------------------
  initial
  begin
    repeat (40000) @(posedge clk_i);
    err_count++;
    finish_test();
  end

  // ------------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------------
  initial
  begin
    logic [31:0] r;
    logic [7:0]  a;
    clk_i = 1'b0;
    rst_n_i = 1'b0;
    addr_i = 8'h00;
    wdata_i = 8'h00;
    wr_i = 1'b0;
    rd_i = 1'b0;
    hot_cmp_i = 6'h00;
    cold_cmp_i = 6'h00;
    ov_cmp_i = 1'b0;
    uv_cmp_i = 1'b0;
    bal_cmp_i = 1'b0;
    ov_code_i = 7'h00;
    uv_code_i = 7'h00;
    err_count = 0;
    num_checks = 0;
    rng_q = 32'h4AA8DCF6;
    shadow = '{8'h00, 8'h00, 8'h00};
    lim = '{500, 1000, 2000, SLOW};
    repeat (8) @(posedge clk_i);
    rst_n_i <= 1'b1;
    cycles(2);
    chk(16'(hot_trip_level_o), 16'h0014);
    chk(16'(cold_trip_level_o), 16'h003C);
    chk(16'(ov_trip_mv_o), 16'h07D0);
    chk(16'(uv_trip_mv_o), 16'h02BC);
    rd_chk(ADDR_TEMP_PROT_EN, 8'h00);
    rd_chk(ADDR_TEMP_THRESH, 8'h00);
    rd_chk(ADDR_FILTER_TIME, 8'h00);
    rd_chk(ADDR_EVT_MASK, 8'h00);
    cycles(1);
    chk(16'(rdata_o), 16'h0000);
    // random writes with an unmapped place and clamp-edge codes
    for (int i = 0; i < 24; i++)
    begin
      r = xorshift();
      case (r[1:0])
        2'h0: a = ADDR_TEMP_PROT_EN;
        2'h1: a = ADDR_TEMP_THRESH;
        2'h2: a = ADDR_FILTER_TIME;
        default: a = 8'h5A;
      endcase
      reg_wr(a, r[15:8]);
      if (a != 8'h5A)
        shadow[a - ADDR_TEMP_PROT_EN] = r[15:8];
      ov_code_i <= (i == 0) ? 7'h77 : (i == 1) ? 7'h78 :
                   (i == 2) ? 7'h7F : r[22:16];
      uv_code_i <= (i == 3) ? 7'h7F : r[30:24];
      cycles(2);
      chk(16'(temp_prot_en_o), 16'(shadow[0][5:0]));
      chk(16'(hot_trip_level_o), 16'h0014 + 16'(shadow[1][7:4]));
      chk(16'(cold_trip_level_o), 16'h003C + 16'(shadow[1][3:0]));
      chk(16'(thermal_filter_time_o), 16'(shadow[2][3:2]));
      chk(16'(voltage_filter_time_o), 16'(shadow[2][1:0]));
      chk(16'(ov_trip_mv_o), exp_ov(ov_code_i));
      chk(16'(uv_trip_mv_o), exp_uv(uv_code_i));
      rd_chk(a, (a == 8'h5A) ? 8'h00 : shadow[a - ADDR_TEMP_PROT_EN]);
    end
    reg_wr(ADDR_TEMP_PROT_EN, 8'h21);
    reg_wr(ADDR_EVT_MASK, 8'h1F);
    for (int c = 0; c < 4; c++)
    begin
      reg_wr(ADDR_FILTER_TIME, 8'((c << 2) | c));
      filt_run(0, lim[c]);
      filt_run(2, lim[c]);
    end
    filt_run(1, SLOW);
    filt_run(3, SLOW);
    filt_run(4, SLOW);
    // disabled channel never flags; enabling starts timing afresh
    @(posedge clk_i);
    hot_cmp_i[1] <= 1'b1;
    cycles(SLOW + 6);
    chk(16'(hot_flag_o[1]), 16'h0000);
    rd_chk(ADDR_EVT_STATUS, 8'h00);
    reg_wr(ADDR_EVT_MASK, 8'h00);
    reg_wr(ADDR_TEMP_PROT_EN, 8'h23);
    cycles(SLOW + 6);
    chk(16'(hot_flag_o[1]), 16'h0001);
    chk(16'(irq_o), 16'h0000);
    rd_chk(ADDR_EVT_STATUS, 8'h01);
    reg_wr(ADDR_TEMP_PROT_EN, 8'h21);
    cycles(2);
    chk(16'(hot_flag_o[1]), 16'h0000);
    finish_test();
  end
endmodule : test_protector_comparator_config
`default_nettype wire
